// [hdl/ioc_pin_io_logic.sv]
// pin i/o logic: input, output and tri-state register blocks plus
// input and output gearboxes, configured over apb
// assumes clk_i is the fast edge clock and that pads are source-synchronous to it
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ioc_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module ioc_pin_io_logic #(
    parameter int DLY_DEPTH = 32
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // apb slave
    input  wire logic       psel_i,
    input  wire logic       penable_i,
    input  wire logic       pwrite_i,
    input  wire logic [7:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic            pready_o,
    output logic            pslverr_o,
    // register block control
    input  wire logic       ce_i,
    input  wire logic       lsr_i,
    // input register block
    input  wire logic       pad_in_i,
    output logic            bypass_input_o,
    output logic            bypass_clock_out_o,
    output logic            rise_edge_capture_o,
    output logic            fall_edge_capture_o,
    // output and tri-state register blocks
    input  wire logic       core_out_first_i,
    input  wire logic       core_out_second_i,
    input  wire logic       core_output_enable_i,
    output logic            pad_out_o,
    output logic            buffer_output_enable_n_o,
    // input gearbox
    input  wire logic       deser_third_serial_i,
    input  wire logic [1:0] word_align_request_i,
    output logic      [7:0] deser_word_o,
    output logic      [1:0] deser_valid_o,
    // output gearbox
    input  wire logic [7:0] par_word_i,
    output logic            ser_word_take_o,
    output logic      [1:0] ser_pad_o
);

    ////////////////////////////////////////////////////////////////////////////
    // apb register file
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] prdata_nxt;
    logic        pready_nxt, pslverr_nxt;
    logic        setup_w, hit_w;
    logic [31:0] status_w;

    ioc_pkg::ioc_gb_mode_e igb_mode_w, ogb_mode_w;
    logic [4:0]  igb_ratio_w, ogb_ratio_w;

    // unknown codes fall back to the full-width ratio
    always_comb begin
        unique case (ctrl_r[`IOC_CTRL_IGB_LSB +: 2])
            2'h1:    igb_mode_w = ioc_pkg::IOC_GB_SEVEN;
            2'h2:    igb_mode_w = ioc_pkg::IOC_GB_FOUR;
            default: igb_mode_w = ioc_pkg::IOC_GB_EIGHT;
        endcase
        unique case (ctrl_r[`IOC_CTRL_OGB_LSB +: 2])
            2'h1:    ogb_mode_w = ioc_pkg::IOC_GB_SEVEN;
            2'h2:    ogb_mode_w = ioc_pkg::IOC_GB_FOUR;
            default: ogb_mode_w = ioc_pkg::IOC_GB_EIGHT;
        endcase
        igb_ratio_w = (igb_mode_w == ioc_pkg::IOC_GB_SEVEN) ? `IOC_RATIO_SEVEN :
                      (igb_mode_w == ioc_pkg::IOC_GB_FOUR)  ? `IOC_RATIO_FOUR : `IOC_RATIO_EIGHT;
        ogb_ratio_w = (ogb_mode_w == ioc_pkg::IOC_GB_SEVEN) ? `IOC_RATIO_SEVEN :
                      (ogb_mode_w == ioc_pkg::IOC_GB_FOUR)  ? `IOC_RATIO_FOUR : `IOC_RATIO_EIGHT;
    end

    // answer is prepared in setup so that the access phase never waits
    always_comb begin
        setup_w     = psel_i && !penable_i;
        hit_w       = (paddr_i == `IOC_ADDR_CTRL) || (paddr_i == `IOC_ADDR_STATUS);
        pready_nxt  = setup_w;
        pslverr_nxt = setup_w && !hit_w;
        prdata_nxt  = 32'h0000_0000;
        if (setup_w && !pwrite_i && paddr_i == `IOC_ADDR_CTRL) begin
            prdata_nxt = ctrl_r;
        end else if (setup_w && !pwrite_i && paddr_i == `IOC_ADDR_STATUS) begin
            prdata_nxt = status_w;
        end
        ctrl_nxt = ctrl_r;
        if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == `IOC_ADDR_CTRL) begin
            ctrl_nxt = pwdata_i & `IOC_CTRL_MASK;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r    <= `IOC_CTRL_RESET;
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            prdata_o  <= prdata_nxt;
            pready_o  <= pready_nxt;
            pslverr_o <= pslverr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input register block with delay line
    logic [DLY_DEPTH-1:0] dly_r, dly_nxt;
    logic                 din_w, rise_nxt, fall_nxt;
    logic [4:0]           del_w;

    // delay taps are whole edge clock cycles; a setting of 0 is one cycle
    always_comb begin
        del_w   = ctrl_r[`IOC_CTRL_DEL_LSB +: 5];
        dly_nxt = {dly_r[DLY_DEPTH-2:0], pad_in_i};
        if (ctrl_r[`IOC_CTRL_DYN_DLY]) begin
            din_w = dly_r[del_w];
        end else if (ctrl_r[`IOC_CTRL_FIX_DLY]) begin
            din_w = dly_r[`IOC_FIX_DLY_TAPS];
        end else begin
            din_w = pad_in_i;
        end
        rise_nxt = lsr_i ? 1'b0 : (ce_i ? din_w : rise_edge_capture_o);
        fall_nxt = lsr_i ? 1'b0 :
                   (ce_i ? (ctrl_r[`IOC_CTRL_IN_DDR] ? din_w : rise_edge_capture_o)
                         : fall_edge_capture_o);
    end

    // bypass skips delay and registers, so it cannot come from a flop
    assign bypass_input_o     = ctrl_r[`IOC_CTRL_BYPASS] & pad_in_i;
    assign bypass_clock_out_o = ctrl_r[`IOC_CTRL_BYPASS] & pad_in_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dly_r               <= '0;
            rise_edge_capture_o <= 1'b0;
        end else begin
            dly_r               <= dly_nxt;
            rise_edge_capture_o <= rise_nxt;
        end
    end

    always_ff @(negedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fall_edge_capture_o <= 1'b0;
        end else begin
            fall_edge_capture_o <= fall_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output and tri-state register blocks
    logic q0_r, q0_nxt, q1a_r, q1a_nxt, q1_r, q1_nxt, lat_r, lat_nxt, oe_n_nxt;

    always_comb begin
        q0_nxt   = lsr_i ? 1'b0 : (ce_i ? core_out_first_i : q0_r);
        q1a_nxt  = lsr_i ? 1'b0 : (ce_i ? core_out_second_i : q1a_r);
        q1_nxt   = lsr_i ? 1'b0 : (ce_i ? q1a_r : q1_r);
        lat_nxt  = lsr_i ? 1'b0 : (ce_i ? core_out_first_i : lat_r);
        oe_n_nxt = lsr_i ? 1'b1 : (ce_i ? !core_output_enable_i : buffer_output_enable_n_o);
    end

    // the pad mux follows the clock level, so it is combinational by nature
    always_comb begin
        if (ctrl_r[`IOC_CTRL_OUT_DDR]) begin
            pad_out_o = clk_i ? q0_r : q1_r;
        end else if (ctrl_r[`IOC_CTRL_OUT_LAT]) begin
            pad_out_o = clk_i ? core_out_first_i : lat_r;
        end else begin
            pad_out_o = q0_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q0_r                     <= 1'b0;
            q1a_r                    <= 1'b0;
            buffer_output_enable_n_o <= 1'b1;
        end else begin
            q0_r                     <= q0_nxt;
            q1a_r                    <= q1a_nxt;
            buffer_output_enable_n_o <= oe_n_nxt;
        end
    end

    // latch closes on the falling edge: held value is d0 at that edge
    always_ff @(negedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q1_r  <= 1'b0;
            lat_r <= 1'b0;
        end else begin
            q1_r  <= q1_nxt;
            lat_r <= lat_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input gearbox, lane 0 is the first cell, lane 1 the third cell
    logic [1:0] ser_in_w;
    logic [1:0] upd_w;
    logic [7:0] lword_w [2];
    logic [7:0] dword_nxt;
    logic [1:0] dvld_nxt;

    assign ser_in_w = {deser_third_serial_i, din_w};

    genvar gl;
    generate
        for (gl = 0; gl < 2; gl++) begin : g_deser
            logic        fs_r, fs_nxt;
            logic [15:0] hist_r, hist_nxt;
            logic [4:0]  av_r, av_nxt, sum_w, sel_w, rat_w;
            logic        on_w;

            // lane 1 only exists as the second 1:4 gearbox
            always_comb begin
                on_w   = (gl == 0) || (igb_mode_w == ioc_pkg::IOC_GB_FOUR);
                rat_w  = igb_ratio_w;
                fs_nxt = lsr_i ? 1'b0 : ser_in_w[gl];
                // a slip drops the falling sample, moving the boundary one bit
                if (word_align_request_i[gl]) begin
                    hist_nxt = {hist_r[14:0], ser_in_w[gl]};
                    sum_w    = av_r + 5'h01;
                end else begin
                    hist_nxt = {hist_r[13:0], fs_r, ser_in_w[gl]};
                    sum_w    = av_r + 5'h02;
                end
                upd_w[gl]   = on_w && (sum_w >= rat_w);
                sel_w       = upd_w[gl] ? (sum_w - rat_w) : 5'h00;
                av_nxt      = upd_w[gl] ? sel_w : sum_w;
                lword_w[gl] = 8'h00;
                // oldest bit of the word lands in bit 0
                for (int i = 0; i < 8; i++) begin
                    if (i < int'(rat_w)) begin
                        lword_w[gl][i] = hist_nxt[4'(int'(sel_w) + int'(rat_w) - 1 - i)];
                    end
                end
                if (lsr_i || !on_w) begin
                    hist_nxt = 16'h0000;
                    av_nxt   = 5'h00;
                end
            end

            always_ff @(negedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    fs_r <= 1'b0;
                end else begin
                    fs_r <= fs_nxt;
                end
            end

            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    hist_r <= 16'h0000;
                    av_r   <= 5'h00;
                end else begin
                    hist_r <= hist_nxt;
                    av_r   <= av_nxt;
                end
            end
        end
    endgenerate

    // stage three merges lane words into the core-facing register
    always_comb begin
        dword_nxt = deser_word_o;
        dvld_nxt  = lsr_i ? 2'h0 : upd_w;
        if (lsr_i) begin
            dword_nxt = 8'h00;
        end else if (igb_mode_w == ioc_pkg::IOC_GB_FOUR) begin
            if (upd_w[0]) dword_nxt[7:4] = lword_w[0][3:0];
            if (upd_w[1]) dword_nxt[3:0] = lword_w[1][3:0];
        end else if (upd_w[0]) begin
            dword_nxt = lword_w[0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            deser_word_o  <= 8'h00;
            deser_valid_o <= 2'h0;
        end else begin
            deser_word_o  <= dword_nxt;
            deser_valid_o <= dvld_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output gearbox, lane 0 is the first cell, lane 1 the third cell
    logic [7:0] cap_r, cap_nxt;
    logic [1:0] need_w;
    logic [1:0] rb_r, fb_r;

    // stage one: the word on par_word_i is taken at the edge where take is high
    always_comb begin
        cap_nxt = lsr_i ? 8'h00 : (ser_word_take_o ? par_word_i : cap_r);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_r           <= 8'h00;
            ser_word_take_o <= 1'b0;
        end else begin
            cap_r           <= cap_nxt;
            ser_word_take_o <= !lsr_i && need_w[0];
        end
    end

    generate
        for (gl = 0; gl < 2; gl++) begin : g_ser
            logic [15:0] qs_r, qs_nxt, rest_w;
            logic [4:0]  qc_r, qc_nxt, left_w;
            logic [7:0]  win_w;
            logic        on_w, rb_nxt, fb_nxt;

            always_comb begin
                on_w = (gl == 0) || (ogb_mode_w == ioc_pkg::IOC_GB_FOUR);
                // lane word by ratio; unused bits are masked off
                if (ogb_mode_w == ioc_pkg::IOC_GB_FOUR) begin
                    win_w = (gl == 0) ? {4'h0, cap_r[3:0]} : {4'h0, cap_r[7:4]};
                end else if (ogb_mode_w == ioc_pkg::IOC_GB_SEVEN) begin
                    win_w = {1'b0, cap_r[6:0]};
                end else begin
                    win_w = cap_r;
                end
                // an empty queue sends zeros rather than stale bits
                if (qc_r >= 5'h02) begin
                    rb_nxt = qs_r[0];
                    fb_nxt = qs_r[1];
                    rest_w = qs_r >> 2;
                    left_w = qc_r - 5'h02;
                end else begin
                    rb_nxt = 1'b0;
                    fb_nxt = 1'b0;
                    rest_w = qs_r;
                    left_w = qc_r;
                end
                need_w[gl] = on_w && (left_w < 5'h02);
                if (need_w[gl]) begin
                    qs_nxt = rest_w | ({8'h00, win_w} << left_w);
                    qc_nxt = left_w + ogb_ratio_w;
                end else begin
                    qs_nxt = rest_w;
                    qc_nxt = left_w;
                end
                if (lsr_i || !on_w) begin
                    qs_nxt = 16'h0000;
                    qc_nxt = 5'h00;
                    rb_nxt = 1'b0;
                    fb_nxt = 1'b0;
                end
            end

            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    qs_r     <= 16'h0000;
                    qc_r     <= 5'h00;
                    rb_r[gl] <= 1'b0;
                    fb_r[gl] <= 1'b0;
                end else begin
                    qs_r     <= qs_nxt;
                    qc_r     <= qc_nxt;
                    rb_r[gl] <= rb_nxt;
                    fb_r[gl] <= fb_nxt;
                end
            end

            // earlier bit while the clock is high, later bit while low
            assign ser_pad_o[gl] = clk_i ? rb_r[gl] : fb_r[gl];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // status word shows the block's own state
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[`IOC_STAT_WORD_LSB +: 8] = deser_word_o;
        status_w[`IOC_STAT_VLD_LSB +: 2]  = deser_valid_o;
        status_w[`IOC_STAT_RISE]          = rise_edge_capture_o;
        status_w[`IOC_STAT_FALL]          = fall_edge_capture_o;
        status_w[`IOC_STAT_OE]            = !buffer_output_enable_n_o;
    end

endmodule // ioc_pin_io_logic

`default_nettype wire

// [hdl/ioc_defines.svh]
// register offsets, control field positions, reset values and counts
// for the pin i/o logic block; included by the top module and the bench
`ifndef IOC_DEFINES_SVH
`define IOC_DEFINES_SVH

// byte addresses of the apb registers
`define IOC_ADDR_CTRL     8'h00
`define IOC_ADDR_STATUS   8'h04

// control register field positions
`define IOC_CTRL_BYPASS   0
`define IOC_CTRL_IN_DDR   1
`define IOC_CTRL_OUT_DDR  2
`define IOC_CTRL_OUT_LAT  3
`define IOC_CTRL_FIX_DLY  4
`define IOC_CTRL_DYN_DLY  5
`define IOC_CTRL_DEL_LSB  8
`define IOC_CTRL_IGB_LSB  16
`define IOC_CTRL_OGB_LSB  18

// reset value and writable bits of the control register
`define IOC_CTRL_RESET    32'h0000_0000
`define IOC_CTRL_MASK     32'h000F_1F3F

// status register field positions
`define IOC_STAT_WORD_LSB 0
`define IOC_STAT_VLD_LSB  8
`define IOC_STAT_RISE     12
`define IOC_STAT_FALL     13
`define IOC_STAT_OE       14

// fixed input delay tap; the delay is this plus one edge clock cycle
`define IOC_FIX_DLY_TAPS  5'h04

// bits per word for each gearbox ratio
`define IOC_RATIO_SEVEN   5'h07
`define IOC_RATIO_EIGHT   5'h08
`define IOC_RATIO_FOUR    5'h04

`endif

// [hdl/ioc_pkg.sv]
// types shared by the pin i/o logic block
// assumes ioc_defines.svh is on the include path
`default_nettype none

package ioc_pkg;

    // gearbox ratio selection, as held in the control register
    typedef enum logic [1:0] {
        IOC_GB_EIGHT = 2'h0,
        IOC_GB_SEVEN = 2'h1,
        IOC_GB_FOUR  = 2'h2
    } ioc_gb_mode_e;

endpackage

`default_nettype wire

// [tb/ioc_pad_model.sv]
// pad-side serial source for the pad and third-cell inputs
// assumes a ddr source: one new bit after every clock edge
`timescale 1ns/100ps
`default_nettype none
module ioc_pad_model (
    // clock and repeating pattern
    input  wire logic       clk_i,
    input  wire logic [7:0] pat_i,
    input  wire logic [3:0] len_i,
    // serial lines toward the block
    output logic            pad_o,
    output logic            third_o
);
    logic [3:0] idx_r = 4'h0;
    // lines start low so the block never sees an unknown level
    initial begin
        pad_o = 1'h0;
        third_o = 1'h0;
    end
    // both edges carry data, so the stream runs at twice the edge clock
    always @(clk_i) begin
        idx_r <= (idx_r + 4'h1 >= len_i) ? 4'h0 : idx_r + 4'h1;
        pad_o <= pat_i[idx_r[2:0]];
        third_o <= pat_i[idx_r[2:0]];
    end
endmodule // ioc_pad_model
`default_nettype wire

// [tb/ioc_pin_io_logic_asserts.sv]
// port-level checker for the pin i/o logic block
// assumes one clock and the asynchronous reset rst_i
`timescale 1ns/100ps
`default_nettype none
module ioc_pin_io_logic_asserts (
    // watched ports
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        ce_i,
    input wire logic        lsr_i,
    input wire logic        pad_in_i,
    input wire logic        bypass_input_o,
    input wire logic        bypass_clock_out_o,
    input wire logic        core_output_enable_i,
    input wire logic        buffer_output_enable_n_o,
    input wire logic [1:0]  deser_valid_o,
    input wire logic        ser_word_take_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // bus answers and refusals
    a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o) else $error("ready missing");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o) else $error("ready held");
    a_unmapped_error: assert property (pready_o && paddr_i != 8'h00 && paddr_i != 8'h04
        |-> pslverr_o && prdata_o == 32'h0) else $error("unmapped not refused");
    // register blocks
    a_oe_follows_core: assert property (ce_i && !lsr_i |=> buffer_output_enable_n_o == !$past(core_output_enable_i))
        else $error("enable not registered");
    a_ce_holds_oe: assert property (!ce_i && !lsr_i |=> $stable(buffer_output_enable_n_o)) else $error("enable moved");
    a_lsr_clears: assert property (lsr_i |=> buffer_output_enable_n_o && deser_valid_o == 2'h0) else $error("clear missed");
    a_bypass_pure: assert property (bypass_input_o |-> pad_in_i && bypass_clock_out_o) else $error("bypass wrong");
    // gearbox word strobes never stand two cycles, output words come at line rate
    a_take_spaced: assert property (ser_word_take_o |=> !ser_word_take_o) else $error("take twice");
    a_take_regular: assert property (disable iff (rst_i || lsr_i) ser_word_take_o |-> ##[2:4] ser_word_take_o)
        else $error("take late");
    a_valid_spaced: assert property (deser_valid_o[0] |=> !deser_valid_o[0]) else $error("valid twice");
endmodule // ioc_pin_io_logic_asserts
bind ioc_pin_io_logic ioc_pin_io_logic_asserts i_chk (.*);
`default_nettype wire

// [tb/tb_ioc_pin_io_logic.sv]
// self-checking bench for the pin i/o logic block
// assumes the pad model and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "ioc_defines.svh"
module tb_ioc_pin_io_logic;
    // design inputs and outputs
    logic        clk_i = 1'h0, rst_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic        ce_i = 1'h1, lsr_i = 1'h0, core_out_first_i = 1'h0, core_out_second_i = 1'h0;
    logic        core_output_enable_i = 1'h0, pready_o, pslverr_o, pad_in_i, bypass_input_o;
    logic        bypass_clock_out_o, rise_edge_capture_o, fall_edge_capture_o, pad_out_o;
    logic        buffer_output_enable_n_o, deser_third_serial_i, ser_word_take_o;
    logic [1:0]  word_align_request_i = 2'h0, deser_valid_o, ser_pad_o;
    logic [7:0]  paddr_i = 8'h00, par_word_i = 8'h00, deser_word_o;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    // bench state
    logic [31:0] rnd = 32'h427F51B1, rd;
    logic [7:0]  pat = 8'h00, lm, s0, s1;
    logic [3:0]  ln = 4'h8;
    logic [1:0]  md;
    logic        err, pv, pf, pa, pb;
    int          fail_count = 0, compares = 0, n;

    ioc_pin_io_logic i_dut (.*);
    ioc_pad_model i_pad (.clk_i(clk_i), .pat_i(pat), .len_i(ln), .pad_o(pad_in_i), .third_o(deser_third_serial_i));

    // 20 mhz clock
    always #25 clk_i = ~clk_i;

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // true when w is a rotation of p, both len bits wide
    function automatic logic is_rot(input logic [7:0] w, input logic [7:0] p, input logic [3:0] len);
        for (int i = 0; i < len; i++) begin
            if (w === p) return 1'h1;
            p = ((p >> 1) | (p << (len - 1))) & ((8'h01 << len) - 8'h01);
        end
        return 1'h0;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'h1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        n = 0;
        do @(posedge clk_i); while (pready_o !== 1'h1 && ++n < 9);
        // a slave that never answers counts against the run
        if (pready_o !== 1'h1) fail_count++;
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask
    // wait for an edge, then let its updates land
    task automatic settle(input logic rise);
        if (rise) @(posedge clk_i);
        else @(negedge clk_i);
        #10;
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        // reset value, writable bits, unmapped place
        apb(1'h0, `IOC_ADDR_CTRL, 32'h0);
        check(rd, `IOC_CTRL_RESET, "ctrl reset");
        apb(1'h1, `IOC_ADDR_CTRL, 32'hFFFFFFFF);
        apb(1'h0, `IOC_ADDR_CTRL, 32'h0);
        check(rd, `IOC_CTRL_MASK, "ctrl mask");
        apb(1'h1, 8'h08, 32'hFFFFFFFF);
        check({rd[30:0], err}, 32'h1, "unmapped");
        // input cell, sdr then ddr
        for (int c = 0; c < 2; c++) begin
            apb(1'h1, `IOC_ADDR_CTRL, 32'(c) << `IOC_CTRL_IN_DDR);
            pat <= rnd[7:0];
            repeat (8) begin
                settle(1'h0);
                pv = pad_in_i;
                settle(1'h1);
                check(rise_edge_capture_o, pv, "rise");
                pf = pad_in_i;
                settle(1'h0);
                check(fall_edge_capture_o, c ? pf : pv, "fall");
            end
        end
        // output cell: register, ddr, latch
        for (int c = 0; c < 3; c++) begin
            apb(1'h1, `IOC_ADDR_CTRL, 32'(c) << `IOC_CTRL_OUT_DDR);
            for (int k = 0; k < 9; k++) begin
                @(posedge clk_i);
                rnd = xs(rnd);
                core_out_first_i <= rnd[0];
                core_out_second_i <= rnd[1];
                #10;
                if (k > 0) check(pad_out_o, c == 2 ? rnd[0] : pa, "pad high");
                settle(1'h0);
                if (k > 0) check(pad_out_o, c == 1 ? pb : c == 2 ? rnd[0] : pa, "pad low");
                pa = rnd[0];
                pb = rnd[1];
            end
        end
        // random enables, clears and slips
        repeat (40) begin
            @(posedge clk_i);
            rnd = xs(rnd);
            ce_i <= rnd[2];
            lsr_i <= rnd[5:3] == 3'h0;
            core_output_enable_i <= rnd[6];
            word_align_request_i <= rnd[8:7];
        end
        @(posedge clk_i);
        {ce_i, lsr_i, core_output_enable_i, word_align_request_i} <= 5'h1C;
        @(posedge clk_i);
        lsr_i <= 1'h0;
        #5;
        check({buffer_output_enable_n_o, deser_valid_o}, 3'h4, "after clear");
        settle(1'h1);
        check(buffer_output_enable_n_o, 1'h0, "oe driven");
        // status mirrors the driven enable; bypass follows the pad
        apb(1'h0, `IOC_ADDR_STATUS, 32'h0);
        check(rd[`IOC_STAT_OE], 1'h1, "status oe");
        apb(1'h1, `IOC_ADDR_CTRL, 32'h1 << `IOC_CTRL_BYPASS);
        settle(1'h0);
        check({bypass_input_o, bypass_clock_out_o}, {2{pad_in_i}}, "bypass");
        // every gearbox code, both directions at once
        for (int m = 0; m < 4; m++) begin
            md = 2'(m);
            ln = md == ioc_pkg::IOC_GB_SEVEN ? 4'h7 : md == ioc_pkg::IOC_GB_FOUR ? 4'h4 : 4'h8;
            lm = (8'h01 << ln) - 8'h01;
            // clear both gearboxes across the ratio change so no stale bits remain
            lsr_i <= 1'h1;
            apb(1'h1, `IOC_ADDR_CTRL, {12'h000, md, md, 16'h0000});
            lsr_i <= 1'h0;
            rnd = xs(rnd);
            pat <= rnd[7:0] & lm;
            par_word_i <= rnd[15:8];
            @(posedge clk_i);
            word_align_request_i <= 2'h3;
            @(posedge clk_i);
            word_align_request_i <= 2'h0;
            n = 0;
            repeat (40) begin
                settle(1'h1);
                s0 = {ser_pad_o[0], s0[7:1]};
                s1 = {ser_pad_o[1], s1[7:1]};
                if (deser_valid_o[0] === 1'h1 && ++n > 3) check(is_rot(md == ioc_pkg::IOC_GB_FOUR ?
                    {4'h0, deser_word_o[7:4]} : deser_word_o, pat, ln), 1'h1, "lane0 word");
                if (deser_valid_o[1] === 1'h1 && n > 3) check(md == ioc_pkg::IOC_GB_FOUR &&
                    is_rot({4'h0, deser_word_o[3:0]}, pat, 4'h4), 1'h1, "lane1 word");
                settle(1'h0);
                s0 = {ser_pad_o[0], s0[7:1]};
                s1 = {ser_pad_o[1], s1[7:1]};
            end
            check(is_rot(s0 >> (8 - ln), par_word_i & lm, ln), 1'h1, "serial lane0");
            if (md == ioc_pkg::IOC_GB_FOUR) check(is_rot(s1 >> 4, par_word_i >> 4, 4'h4), 1'h1, "serial lane1");
        end
        print_verdict();
    end
endmodule // tb_ioc_pin_io_logic
`default_nettype wire
